// File: conv_host_params.svh
`ifndef CONV_HOST_PARAMS_SVH
`define CONV_HOST_PARAMS_SVH

`define DATA_W          8
`define CLK_PERIOD_NS   4
// longest conversion time, write-then-read mode
`define CONV_TIME_NS    560
`define CONV_CYC        ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// least strobe width the host drives
`define STROBE_NS       40
`define STROBE_CYC      ((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// ready_n / done wait limit before giving up
`define TIMEOUT_CYC     1024
// cycles after chip select falls while synced ready_n is still stale
`define RDY_BLIND       2
`define CNT_W           11
`define CNT_ZERO        11'h000
`define CNT_ONE         11'h001
`define ALL_ONES        8'hff
`define DATA_ZERO       8'h00

`endif

// File: conv_host_pkg.sv
package conv_host_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_WRLO  = 3'b001,
    ST_WAIT  = 3'b010,
    ST_RDLO  = 3'b011,
    ST_RDEND = 3'b100
  } state_t;

  typedef struct packed {
    logic cs_n;
    logic wr_n;
    logic rd_n;
    logic mode;
  } strobes_t;

  typedef struct packed {
    logic       valid;
    logic       overflow;
    logic       timeout;
    logic [7:0] data;
  } result_t;
endpackage

// File: conv_host_sync.sv
`timescale 1ns/10ps
// two-flop synchroniser for the converter's asynchronous outputs
module conv_host_sync #(
  parameter int W = 11
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '1;
      sync_q <= '1;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule

// File: conv_host.sv
`timescale 1ns/10ps
`include "conv_host_params.svh"
// Functional notes
// - mode pin high: write-then-read, low: read-only
// - write-then-read starts on write strobe rising edge
// - read-only starts on read strobe falling edge
// - read-only: hold read low until result
module conv_host (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   start,
  input  wire logic                   mode_sel,
  input  wire logic [`DATA_W-1:0]     result_bus,
  input  wire logic                   ready_n,
  input  wire logic                   conversion_done_n,
  input  wire logic                   overflow_flag_n,
  output logic                        chip_select_n,
  output logic                        write_strobe_n,
  output logic                        read_strobe_n,
  output logic                        mode,
  output logic                        busy,
  output conv_host_pkg::result_t      result
);
  logic [`DATA_W+2:0] pins_s;
  logic [`DATA_W-1:0] bus_s;
  logic               rdy_s;
  logic               done_s;
  logic               ofl_s;

  conv_host_sync #(.W(`DATA_W + 3)) u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in ({result_bus, ready_n, conversion_done_n, overflow_flag_n}),
    .sync_out (pins_s)
  );
  assign bus_s  = pins_s[`DATA_W+2:3];
  assign rdy_s  = pins_s[2];
  assign done_s = pins_s[1];
  assign ofl_s  = pins_s[0];

  conv_host_pkg::state_t   st_q, st_d;
  conv_host_pkg::strobes_t pin_q, pin_d;
  conv_host_pkg::result_t  res_q, res_d;
  logic [`CNT_W-1:0]       cnt_q, cnt_d;
  logic                    busy_q, busy_d;
  logic                    cnt_done;
  logic                    rdy_seen;

  // synced ready_n still shows the idle pull-up for a few cycles after
  // chip select falls; trusting it then would end the read at once
  assign cnt_done = (cnt_q == `CNT_ZERO);
  assign rdy_seen = rdy_s && (cnt_q < `CNT_W'(`TIMEOUT_CYC - `RDY_BLIND));

  // overflow forces all ones whatever the bus happens to show
  function automatic logic [`DATA_W-1:0] pick_data(
    input logic               ofl_n,
    input logic [`DATA_W-1:0] bus
  );
    if (!ofl_n) begin
      return `ALL_ONES;
    end
    return bus;
  endfunction

  // read-only waits on ready_n, so its counter is only a watchdog
  function automatic logic [`CNT_W-1:0] first_count(input logic wr_mode);
    if (wr_mode) begin
      return `CNT_W'(`STROBE_CYC);
    end
    return `CNT_W'(`TIMEOUT_CYC);
  endfunction

  // mode is held steady for the whole transaction
  always_comb begin
    st_d   = st_q;
    pin_d  = pin_q;
    res_d  = res_q;
    cnt_d  = cnt_q;
    busy_d = busy_q;
    res_d.valid = 1'b0;
    if (cnt_q != `CNT_ZERO) begin
      cnt_d = cnt_q - `CNT_ONE;
    end
    case (st_q)
      conv_host_pkg::ST_IDLE: begin
        pin_d.cs_n = 1'b1;
        pin_d.wr_n = 1'b1;
        pin_d.rd_n = 1'b1;
        if (start) begin
          busy_d     = 1'b1;
          pin_d.mode = mode_sel;
          pin_d.cs_n = 1'b0;
          cnt_d      = first_count(mode_sel);
          if (mode_sel) begin
            pin_d.wr_n = 1'b0;
            st_d       = conv_host_pkg::ST_WRLO;
          end else begin
            pin_d.rd_n = 1'b0;
            st_d       = conv_host_pkg::ST_RDLO;
          end
        end
      end
      conv_host_pkg::ST_WRLO: begin
        if (cnt_done) begin
          pin_d.wr_n = 1'b1;
          cnt_d      = `CNT_W'(`CONV_CYC + `TIMEOUT_CYC);
          st_d       = conv_host_pkg::ST_WAIT;
        end
      end
      conv_host_pkg::ST_WAIT: begin
        // done_n marks latch loaded; running out the count ends in a timeout, not a read
        if (!done_s) begin
          pin_d.rd_n = 1'b0;
          cnt_d      = `CNT_W'(`STROBE_CYC + 2);
          st_d       = conv_host_pkg::ST_RDLO;
        end else if (cnt_done) begin
          // no done_n at all: give up, release select and report it
          res_d.timeout = 1'b1;
          res_d.valid   = 1'b1;
          pin_d.cs_n    = 1'b1;
          busy_d        = 1'b0;
          st_d          = conv_host_pkg::ST_IDLE;
        end
      end
      conv_host_pkg::ST_RDLO: begin
        // read-only: rd_n stays low until ready_n releases; the sync
        // adds two cycles so data on the bus has settled by then
        if (pin_q.mode ? cnt_done : rdy_seen) begin
          res_d.data     = pick_data(ofl_s, bus_s);
          res_d.overflow = !ofl_s;
          res_d.timeout  = 1'b0;
          pin_d.rd_n     = 1'b1;
          st_d           = conv_host_pkg::ST_RDEND;
        end else if (!pin_q.mode && cnt_done) begin
          // ready_n never released: end the read and flag the timeout
          res_d.timeout = 1'b1;
          pin_d.rd_n    = 1'b1;
          st_d          = conv_host_pkg::ST_RDEND;
        end
      end
      conv_host_pkg::ST_RDEND: begin
        // select rises one cycle after the read strobe, never with it
        pin_d.cs_n  = 1'b1;
        res_d.valid = 1'b1;
        busy_d      = 1'b0;
        st_d        = conv_host_pkg::ST_IDLE;
      end
      default: begin
        st_d = conv_host_pkg::ST_IDLE;
      end
    endcase
  end

  // one register group per state item, each reset to its idle value
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= conv_host_pkg::ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // strobes idle high so the device sees no edge as reset is released
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_q.cs_n <= 1'b1;
      pin_q.wr_n <= 1'b1;
      pin_q.rd_n <= 1'b1;
      pin_q.mode <= 1'b0;
    end else begin
      pin_q <= pin_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      res_q.valid    <= 1'b0;
      res_q.overflow <= 1'b0;
      res_q.timeout  <= 1'b0;
      res_q.data     <= `DATA_ZERO;
    end else begin
      res_q <= res_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= `CNT_ZERO;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= busy_d;
    end
  end

  assign chip_select_n  = pin_q.cs_n;
  assign write_strobe_n = pin_q.wr_n;
  assign read_strobe_n  = pin_q.rd_n;
  assign mode           = pin_q.mode;
  assign busy           = busy_q;
  assign result         = res_q;
endmodule

// File: conv_host_sva.sv
`timescale 1ns/10ps
module conv_host_sva (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic mode_sel,
  input wire logic ready_n,
  input wire logic conversion_done_n,
  input wire logic chip_select_n,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic mode,
  input wire logic busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_MODE_WR: assert property (
    start && !busy && mode_sel |=> mode && !write_strobe_n)
    else $error("write mode start wrong");
  AST_MODE_RD: assert property (
    start && !busy && !mode_sel |=> !mode && !read_strobe_n && !chip_select_n)
    else $error("read mode start wrong");
  AST_WR_QUAL: assert property (
    $rose(write_strobe_n) |-> !chip_select_n && mode)
    else $error("write edge unqualified");
  AST_WR_WIDTH: assert property (
    $fell(write_strobe_n) |->
      (!write_strobe_n)[*8] ##1 (!write_strobe_n)[*3] ##1 write_strobe_n)
    else $error("write strobe width");
  AST_RD_QUAL: assert property (
    $fell(read_strobe_n) |-> !chip_select_n)
    else $error("read edge unqualified");
  AST_RD_HOLD: assert property (
    !mode && !read_strobe_n && !ready_n |=> !read_strobe_n)
    else $error("read released early");
  AST_WR_READ: assert property (
    mode && $fell(read_strobe_n) |-> !$past(conversion_done_n, 2))
    else $error("read before done");
  cover property (mode && $rose(read_strobe_n));
  cover property (!mode && $rose(read_strobe_n));
  cover property (mode && $fell(chip_select_n));
endmodule
bind conv_host conv_host_sva conv_host_sva_i (.*);

// File: conv_dev.sv
`timescale 1ns/10ps
module conv_dev (
  input  wire logic        chip_select_n,
  input  wire logic        write_strobe_n,
  input  wire logic        read_strobe_n,
  input  wire logic        mode,
  input  wire logic [8:0]  vin,
  input  wire logic [11:0] dly,
  output wire logic [7:0]  result_bus,
  output wire              ready_n,
  output logic             conversion_done_n,
  output logic             overflow_flag_n
);
  logic [7:0] lat_q = 8'h00;
  logic       rdy_q = 1'b1;
  wire drive = !(chip_select_n | read_strobe_n) && (mode || rdy_q);
  // released bus shows the inverse so a stale byte cannot pass
  assign result_bus = drive ? lat_q : ~lat_q;
  assign ready_n = rdy_q ? 1'bz : 1'b0;
  initial begin
    conversion_done_n = 1'b1;
    overflow_flag_n = 1'b1;
  end
  task automatic convert;
    #(dly);
    lat_q = vin[8] ? 8'hff : vin[7:0];
    overflow_flag_n = !vin[8];
    conversion_done_n = 1'b0;
    rdy_q = 1'b1;
  endtask
  always @(posedge write_strobe_n) if (mode && !chip_select_n) convert();
  // mode settles on the same edge as the strobes, so look a little later
  always @(negedge read_strobe_n) begin
    #1;
    if (!mode && !chip_select_n) convert();
  end
  always @(negedge chip_select_n) begin
    #1;
    if (!mode) rdy_q = 1'b0;
  end
  always @(posedge read_strobe_n) if (!chip_select_n) conversion_done_n = 1'b1;
endmodule

// File: conv_host_test.sv
`timescale 1ns/10ps
module conv_host_test;
  logic clk = 1'b0, rst_n = 1'b0, start = 1'b0, mode_sel = 1'b0;
  logic [8:0] vin = 9'h000;
  logic [11:0] dly = 12'h020;
  wire logic [7:0] result_bus;
  tri1 ready_n;
  wire conversion_done_n, overflow_flag_n, chip_select_n;
  wire write_strobe_n, read_strobe_n, mode, busy;
  conv_host_pkg::result_t result;
  int fail_count = 0, total_checks = 0, cyc = 0;
  conv_host conv_host_i (.*);
  conv_dev conv_dev_i (.*);
  initial forever #2 clk = ~clk;
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      complete_run();
    end
  end
  task automatic check(input logic [10:0] got, input logic [10:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conv(input logic m, input logic [8:0] v, logic [11:0] d);
    int n = 0;
    @(posedge clk);
    vin <= v;
    dly <= d;
    mode_sel <= m;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    @(negedge clk);
    check({10'h000, busy}, 11'h001);
    while (result.valid !== 1'b1 && n < 1500) begin
      @(negedge clk);
      n++;
    end
    check(result, {1'b1, v[8], 1'b0, v[8] ? 8'hff : v[7:0]});
  endtask
  task automatic scen_write_read;
    conv(1'b1, 9'h05a, 12'h230);
    conv(1'b1, 9'h0ff, 12'h020);
  endtask
  task automatic scen_read_only;
    conv(1'b0, 9'h000, 12'h064);
    conv(1'b0, 9'h081, 12'h7d0);
  endtask
  task automatic scen_overflow;
    conv(1'b1, 9'h1a5, 12'h230);
    conv(1'b0, 9'h1ff, 12'h12c);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    scen_write_read();
    scen_read_only();
    scen_overflow();
    complete_run();
  end
endmodule
